/* File: core/cpe_color.sv */
// module: palette registers, luma and chroma phase encoder
// Function
// - nine write-only color registers, reads return nothing
// - pixels select a register, writes recolor immediately
// - upper nibble is hue, zero means grayscale
// - bits 3..1 are luminance, saturation unaffected
// - bit 0 dropped, luma low bit forced zero
// - only blend mode yields odd luminance
// - 4-bit brightness maps 0 black to 15 white
// - NTSC hue zero makes no subcarrier
// - NTSC hue N delayed N units from burst
// - color burst emitted during horizontal blank
// - PAL per-hue tap and inversion per parity
// - PAL hues 1 and 15 share taps 1/5
// - PAL burst uses hue 1 phase selection
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module cpe_color
   import cpe_pkg::*;
#(
   parameter int STEP_DIV = STEP_DIV_DEF
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic [3:0] i_pix_sel,
   input  wire logic       i_blend_en,
   input  wire logic [3:0] i_blend_lum,
   input  wire logic       i_hblank,
   input  wire logic       i_line_odd,
   input  wire logic       i_pal_mode,
   output logic      [3:0] o_luma,
   output logic            o_chroma,
   output logic            o_chroma_en
);

   logic [6:0]  color_ff [CPE_NUM_REGS];
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;
   logic [3:0]  ph_ff;
   logic [3:0]  nxt_ph;
   logic [7:0]  div_ff;
   logic [7:0]  nxt_div;
   logic        step_en;
   logic [3:0]  luma_ff;
   logic [3:0]  nxt_luma;
   logic        chroma_ff;
   logic        nxt_chroma;
   logic        cen_ff;
   logic        nxt_cen;
   logic [6:0]  sel_color;
   logic [3:0]  sel_hue;
   logic [2:0]  sel_lum;
   logic [3:0]  eff_hue;
   logic [3:0]  pal_tap;
   logic        pal_inv;
   logic [4:0]  ntsc_diff;
   logic [3:0]  ntsc_dist;
   logic [3:0]  pal_dist;
   logic        wave;

   // PAL delay tap per hue and line parity
   function automatic logic [3:0] f_pal_tap(input logic [3:0] hue,
                                            input logic       odd);
      logic [3:0] t;
      t = 4'h0;
      case (hue)
         4'h1, 4'hF: t = odd ? 4'h5 : 4'h1;
         4'h2:       t = odd ? 4'h6 : 4'h0;
         4'h3:       t = odd ? 4'h7 : 4'h7;
         4'h4:       t = odd ? 4'h0 : 4'h6;
         4'h5:       t = odd ? 4'h1 : 4'h5;
         4'h6:       t = odd ? 4'h2 : 4'h4;
         4'h7:       t = odd ? 4'h4 : 4'h2;
         4'h8:       t = odd ? 4'h5 : 4'h1;
         4'h9:       t = odd ? 4'h6 : 4'h0;
         4'hA:       t = odd ? 4'h7 : 4'h7;
         4'hB:       t = odd ? 4'h1 : 4'h5;
         4'hC:       t = odd ? 4'h2 : 4'h4;
         4'hD:       t = odd ? 4'h3 : 4'h3;
         4'hE:       t = odd ? 4'h4 : 4'h2;
         default:    t = 4'h0;
      endcase
      return t;
   endfunction : f_pal_tap

   // PAL inversion per hue and line parity
   function automatic logic f_pal_inv(input logic [3:0] hue,
                                      input logic       odd);
      logic v;
      v = 1'b0;
      case (hue)
         4'h3:                      v = !odd;
         4'h4, 4'h5, 4'h6, 4'h7,
         4'h8, 4'h9:                v = 1'b1;
         4'hA:                      v = odd;
         default:                   v = 1'b0;
      endcase
      return v;
   endfunction : f_pal_inv

   // register file: bit 0 of the written byte is never stored
   generate
      for (genvar g = 0; g < CPE_NUM_REGS; g++)
      begin : g_color
         logic [6:0] nxt_color;
         always_comb
         begin
            nxt_color = color_ff[g];
            if (i_wr && i_addr == 4'(g))
            begin
               nxt_color = i_wdata[HUE_MSB:LUM_LSB];
            end
         end
         always_ff @(posedge i_clk)
         begin
            if (!i_rst_n)
               color_ff[g] <= COLOR_RST;
            else
               color_ff[g] <= nxt_color;
         end
      end
   endgenerate

   // write-only: every read, mapped or not, answers zero
   always_comb
   begin
      nxt_rdata = 8'h00;
   end

   // phase wheel; a slower subcarrier just needs a larger divider
   always_comb
   begin
      step_en = (div_ff == 8'(STEP_DIV - 1));
      nxt_div = step_en ? 8'h00 : div_ff + 8'h01;
      nxt_ph  = ph_ff;
      if (step_en)
      begin
         if (!i_pal_mode && ph_ff >= NTSC_LAST_STEP)
            nxt_ph = 4'h0;
         else if (i_pal_mode && ph_ff == PAL_LAST_STEP)
            nxt_ph = 4'h0;
         else
            nxt_ph = ph_ff + 4'h1;
      end
   end

   // pixel path: selected register, then hue to phase
   always_comb
   begin
      if (i_pix_sel <= OFF_LAST)
         sel_color = color_ff[i_pix_sel];
      else
         sel_color = color_ff[OFF_BACKGROUND];
      sel_hue = sel_color[6:3];
      sel_lum = sel_color[2:0];
      eff_hue = i_hblank ? HUE_BURST_PAL : sel_hue;
      pal_tap = f_pal_tap(eff_hue, i_line_odd);
      pal_inv = f_pal_inv(eff_hue, i_line_odd);
      // burst sits at zero delay on NTSC
      if (i_hblank)
         ntsc_diff = {1'b0, ph_ff} + NTSC_STEPS
                     - {1'b0, BURST_TAP_NTSC};
      else
         ntsc_diff = {1'b0, ph_ff} + NTSC_STEPS
                     - {1'b0, sel_hue};
      if (ntsc_diff >= NTSC_STEPS)
         ntsc_diff = ntsc_diff - NTSC_STEPS;
      ntsc_dist = ntsc_diff[3:0];
      pal_dist  = ph_ff - pal_tap;
      if (i_pal_mode)
         wave = (pal_dist < WAVE_HALF) ^ pal_inv;
      else
         wave = (ntsc_dist < WAVE_HALF);
   end

   // output stage; luminance never touches chroma amplitude
   always_comb
   begin
      nxt_luma   = LUMA_BLANK;
      nxt_chroma = 1'b0;
      nxt_cen    = 1'b0;
      if (i_hblank)
      begin
         nxt_chroma = wave;
         nxt_cen    = 1'b1;
      end
      else
      begin
         if (i_blend_en)
            nxt_luma = i_blend_lum;
         else
            nxt_luma = {sel_lum, 1'b0};
         if (sel_hue != HUE_GRAY)
         begin
            nxt_chroma = wave;
            nxt_cen    = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rdata_ff  <= 8'h00;
         ph_ff     <= 4'h0;
         div_ff    <= 8'h00;
         luma_ff   <= LUMA_BLANK;
         chroma_ff <= 1'b0;
         cen_ff    <= 1'b0;
      end
      else
      begin
         rdata_ff  <= nxt_rdata;
         ph_ff     <= nxt_ph;
         div_ff    <= nxt_div;
         luma_ff   <= nxt_luma;
         chroma_ff <= nxt_chroma;
         cen_ff    <= nxt_cen;
      end
   end

   assign o_rdata     = rdata_ff;
   assign o_luma      = luma_ff;
   assign o_chroma    = chroma_ff;
   assign o_chroma_en = cen_ff;

   // helper: last byte written to the background register
   logic [7:0] bg_wr_ff;
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         bg_wr_ff <= 8'h00;
      else if (i_wr && i_addr == OFF_BACKGROUND)
         bg_wr_ff <= i_wdata;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_READ_ZERO: assert property (
      i_rd |=> o_rdata == 8'h00)
      else $error("color register read returned data");

   AST_WRITE_SHOWS: assert property (
      i_wr && i_addr == OFF_BACKGROUND ##1
      (i_pix_sel == OFF_BACKGROUND && !i_hblank && !i_blend_en
       && !i_wr)
      |=> o_luma == {bg_wr_ff[3:1], 1'b0})
      else $error("background write not visible on luma");

   AST_GRAY_NO_CHROMA: assert property (
      !i_hblank && sel_hue == HUE_GRAY
      |=> !o_chroma_en && !o_chroma)
      else $error("grayscale pixel carried chroma");

   AST_LUM_FIELD: assert property (
      !i_hblank && !i_blend_en
      |=> o_luma[3:1] == $past(sel_color[2:0]))
      else $error("luma does not follow register field");

   AST_LSB_ZERO: assert property (
      !i_hblank && !i_blend_en |=> o_luma[0] == 1'b0)
      else $error("register path produced odd luma");

   AST_BLEND_LUMA: assert property (
      !i_hblank && i_blend_en |=> o_luma == $past(i_blend_lum))
      else $error("blend luminance not passed through");

   AST_NTSC_WHEEL: assert property (
      !i_pal_mode && $past(!i_pal_mode) |-> ph_ff <= NTSC_LAST_STEP)
      else $error("ntsc phase wheel exceeded fifteen steps");

   AST_BURST_BLANK: assert property (
      i_hblank |=> o_chroma_en && o_luma == LUMA_BLANK)
      else $error("no burst during blank");

   AST_PAL_INVERT: assert property (
      i_pal_mode && !i_hblank && sel_hue >= 4'h3
      && sel_hue <= 4'hA
      |-> pal_inv == ((sel_hue == 4'h3) ? !i_line_odd
                      : (sel_hue == 4'hA) ? i_line_odd : 1'b1))
      else $error("pal hue inversion wrong for line parity");

   AST_PAL_H15: assert property (
      i_pal_mode && !i_hblank && (sel_hue == 4'hF || sel_hue == 4'h1)
      |-> !pal_inv && pal_tap == (i_line_odd ? 4'h5 : 4'h1))
      else $error("pal hue 1 or 15 taps wrong");

   AST_PAL_BURST: assert property (
      i_pal_mode && i_hblank
      |-> pal_tap == (i_line_odd ? 4'h5 : 4'h1) && !pal_inv)
      else $error("pal burst not on hue 1 phase");

   COV_BURST_NTSC: cover property (
      !i_pal_mode && i_hblank ##1 !i_hblank ##1 o_chroma_en);
   COV_PAL_INV: cover property (
      i_pal_mode && !i_hblank && pal_inv);
   COV_WRITE_THEN_SHOW: cover property (
      i_wr && i_addr == OFF_SPRITE0 ##1 i_pix_sel == OFF_SPRITE0);
   COV_BLEND: cover property (
      i_blend_en && !i_hblank ##1 o_luma[0]);

endmodule : cpe_color
`default_nettype wire

/* File: core/cpe_pkg.sv */
// package: constants for the color palette encoder
package cpe_pkg;
   localparam int          CPE_NUM_REGS   = 9;
   // register offsets on the plain register port
   localparam logic [3:0]  OFF_BACKGROUND = 4'h0;
   localparam logic [3:0]  OFF_PLAYFIELD0 = 4'h1;
   localparam logic [3:0]  OFF_SPRITE0    = 4'h5;
   localparam logic [3:0]  OFF_LAST       = 4'h8;
   // fields of a color register
   localparam int          HUE_MSB        = 7;
   localparam int          HUE_LSB        = 4;
   localparam int          LUM_MSB        = 3;
   localparam int          LUM_LSB        = 1;
   localparam logic [6:0]  COLOR_RST      = 7'h00;
   localparam logic [3:0]  HUE_GRAY       = 4'h0;
   localparam logic [3:0]  HUE_BURST_PAL  = 4'h1;
   // subcarrier phase wheel, one step per delay unit
   localparam logic [3:0]  NTSC_LAST_STEP = 4'hE;
   localparam logic [3:0]  PAL_LAST_STEP  = 4'hF;
   localparam logic [4:0]  NTSC_STEPS     = 5'h0F;
   localparam logic [3:0]  WAVE_HALF      = 4'h8;
   localparam logic [3:0]  BURST_TAP_NTSC = 4'h0;
   localparam logic [3:0]  LUMA_BLANK     = 4'h0;
   localparam int          STEP_DIV_DEF   = 1;
endpackage : cpe_pkg

/* File: bench/cpe_video_rx.sv */
// receiver model: stamps chroma rising edges in burst and in active video
`timescale 1ns/100ps
`default_nettype none
module cpe_video_rx
(
   input  wire logic        i_clk,
   input  wire logic        i_hblank,
   input  wire logic        i_chroma,
   output logic      [15:0] o_burst_t,
   output logic      [15:0] o_act_t
);
   logic [15:0] now_ff   = 16'h0000;
   logic        blank_ff = 1'b0;
   logic        prev_ff  = 1'b0;
   // outputs lag the blank input one edge, so blank is delayed to match
   always_ff @(posedge i_clk)
   begin
      now_ff   <= now_ff + 16'h0001;
      blank_ff <= i_hblank;
      prev_ff  <= i_chroma;
      if (i_chroma && !prev_ff && blank_ff)
         o_burst_t <= now_ff;
      else if (i_chroma && !prev_ff)
         o_act_t <= now_ff;
   end
endmodule : cpe_video_rx
`default_nettype wire

/* File: bench/cpe_color_tb_top.sv */
// self-checking bench for the color palette encoder
`timescale 1ns/100ps
`default_nettype none
module cpe_color_tb_top;
   import cpe_pkg::*;
   logic        i_clk, i_rst_n, i_wr, i_rd, i_blend_en;
   logic        i_hblank, i_line_odd, i_pal_mode;
   logic [3:0]  i_addr, i_pix_sel, i_blend_lum;
   logic [7:0]  i_wdata, o_rdata;
   logic [3:0]  o_luma;
   logic        o_chroma, o_chroma_en;
   logic [15:0] burst_t, act_t, d;
   int          failures = 0;
   int          checked  = 0;

   cpe_color #(.STEP_DIV(1)) i_cpe_color (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_pix_sel(i_pix_sel), .i_blend_en(i_blend_en),
      .i_blend_lum(i_blend_lum), .i_hblank(i_hblank),
      .i_line_odd(i_line_odd), .i_pal_mode(i_pal_mode), .o_luma(o_luma),
      .o_chroma(o_chroma), .o_chroma_en(o_chroma_en));
   cpe_video_rx i_cpe_video_rx (.i_clk(i_clk), .i_hblank(i_hblank),
      .i_chroma(o_chroma), .o_burst_t(burst_t), .o_act_t(act_t));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   // one byte per register, as the host does
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 chk(16'(o_rdata), 16'h0000);
   endtask : rd

   task automatic px(input logic [3:0] s, input logic hb);
      @(posedge i_clk);
      i_pix_sel <= s;
      i_hblank  <= hb;
      @(posedge i_clk);
      #1;
   endtask : px

   // burst then active video; d is the hue delay in phase steps
   task automatic meas(input logic [15:0] period);
      px(4'h0, 1'b1);
      repeat (40) @(posedge i_clk);
      i_hblank <= 1'b0;
      repeat (40) @(posedge i_clk);
      #1 d = (act_t - burst_t) % period;
   endtask : meas

   task automatic t_regs;
      for (int i = 0; i < 9; i++)
         wr(4'(i), {4'h0, 3'(i), 1'b1});
      wr(4'h9, 8'hFF);
      rd(4'h7);
      rd(4'h9);
      for (int i = 0; i < 10; i++)
      begin
         px(4'(i), 1'b0);
         chk(16'(o_luma), 16'({3'(i % 9), 1'b0}));
         chk(16'(o_chroma_en), 16'h0000);
      end
      @(posedge i_clk);
      i_pix_sel <= 4'h1;
      wr(4'h1, 8'h0E);
      @(posedge i_clk);
      #1 chk(16'(o_luma), 16'h000E);
      // background rewritten while it is on screen
      @(posedge i_clk);
      i_pix_sel <= 4'h0;
      wr(4'h0, 8'h5B);
      @(posedge i_clk);
      #1 chk(16'(o_luma), 16'h000A);
      chk(16'(o_chroma_en), 16'h0001);
      $display("register test done");
   endtask : t_regs

   task automatic t_blend;
      for (int v = 0; v < 16; v++)
      begin
         @(posedge i_clk);
         i_blend_en  <= 1'b1;
         i_blend_lum <= 4'(v);
         @(posedge i_clk);
         #1 chk(16'(o_luma), 16'(v));
      end
      @(posedge i_clk);
      i_blend_en <= 1'b0;
      px(4'h1, 1'b1);
      chk(16'(o_luma), 16'h0000);
      chk(16'(o_chroma_en), 16'h0001);
      $display("blend and blank test done");
   endtask : t_blend

   task automatic t_ntsc;
      for (int h = 1; h < 16; h++)
      begin
         wr(4'h0, {4'(h), 3'h5, 1'b0});
         meas(16'd15);
         chk(d, 16'(h % 15));
         chk(16'(o_luma), 16'h000A);
         chk(16'(o_chroma_en), 16'h0001);
      end
      $display("ntsc phase test done");
   endtask : t_ntsc

   task automatic t_pal;
      @(posedge i_clk);
      i_pal_mode <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge i_clk);
         i_line_odd <= k[0];
         wr(4'h0, k[1] ? 8'hF6 : 8'h16);
         meas(16'd16);
         chk(d, 16'h0000);
      end
      $display("pal phase test done");
   endtask : t_pal

   // other hues against the burst: tap, plus half a turn when inverted
   task automatic t_pal_hue;
      logic [3:0]  hue  [4] = '{4'h2, 4'h2, 4'h3, 4'h4};
      logic [15:0] want [4] = '{16'h000F, 16'h0001, 16'h000E, 16'h0003};
      for (int k = 0; k < 4; k++)
      begin
         @(posedge i_clk);
         i_line_odd <= k[0];
         wr(4'h0, {hue[k], 4'h2});
         meas(16'd16);
         chk(d, want[k]);
      end
      $display("pal hue table test done");
   endtask : t_pal_hue

   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   initial
   begin
      #200000;
      failures++;
      final_report();
   end

   initial
   begin
      {i_rst_n, i_wr, i_rd, i_blend_en, i_hblank} = 5'h00;
      {i_line_odd, i_pal_mode} = 2'h0;
      {i_addr, i_pix_sel, i_blend_lum, i_wdata} = 20'h00000;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1 chk(16'({o_rdata, o_luma, o_chroma, o_chroma_en}), 16'h0000);
      t_regs();
      t_blend();
      t_ntsc();
      t_pal();
      t_pal_hue();
      final_report();
   end
endmodule : cpe_color_tb_top
`default_nettype wire
